// ===== logic/sfc_pkg.sv
package sfc_pkg;

  // Serial command codes
  localparam logic [7:0] CMD_READ_ECFG   = 8'h65;
  localparam logic [7:0] CMD_WRITE_ECFG  = 8'h61;
  localparam logic [7:0] CMD_READ_FLAGS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h50;

  // Reset values
  localparam logic [7:0] ECFG_RESET  = 8'hDF;
  localparam logic [7:0] FLAGS_RESET = 8'h80;

  // Drive strength codes that are not allowed
  localparam logic [2:0] DRIVE_RSVD_LO = 3'h0;
  localparam logic [2:0] DRIVE_RSVD_HI = 3'h4;

  // Bits per byte and lane counts
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [2:0] LANES_EXT  = 3'h1;
  localparam logic [2:0] LANES_DUAL = 3'h2;
  localparam logic [2:0] LANES_QUAD = 3'h4;

  // Output enables (low = driving) per protocol
  localparam logic [3:0] OE_N_IDLE = 4'hF;
  localparam logic [3:0] OE_N_EXT  = 4'hD;
  localparam logic [3:0] OE_N_DUAL = 4'hC;
  localparam logic [3:0] OE_N_QUAD = 4'h0;

  // Least dummy cycles the host must program for 108 MHz
  localparam int DUMMY_FAST_108      = 3;
  localparam int DUMMY_DUAL_OUT_108  = 5;
  localparam int DUMMY_DUAL_IO_108   = 7;
  localparam int DUMMY_QUAD_OUT_108  = 7;
  localparam int DUMMY_QUAD_IO_108   = 10;

  typedef struct packed {
    logic       quad_n;
    logic       dual_n;
    logic       rsvd;
    logic       hold_en;
    logic       accel_n;
    logic [2:0] drive;
  } sfc_ecfg_t;

  typedef struct packed {
    logic ready;
    logic erase_susp;
    logic erase_err;
    logic prog_err;
    logic supply_err;
    logic prog_susp;
    logic prot_err;
    logic rsvd;
  } sfc_flags_t;

  typedef struct packed {
    logic busy;
    logic erase_susp;
    logic prog_susp;
  } sfc_status_t;

  typedef struct packed {
    logic erase_fail;
    logic prog_fail;
    logic prog_raise;
    logic supply_high;
    logic len_mult64;
    logic supply_invalid;
    logic protect_viol;
  } sfc_events_t;

  typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD, ST_SKIP} sfc_state_t;

endpackage

// ===== logic/sfc_regs.sv
// Overview of operation
// - Bit 7 low selects four-line protocol
// - Bit 6 low selects two-line protocol
// - Both low: four-line wins
// - Protocol changes only when write completes
// - Bit 4 enables hold/reset pin function
// - Bit 3 low enables supply acceleration
// - Register read/write in every protocol
// - Flag 7 low while controller busy
// - Flag 6 shows erase suspended/pending
// - Flag 2 shows program suspended/pending
// - Flag 5 set on erase failure
// - Flag 4 on program fail, bad raise
// - Flag 3 on invalid supply voltage
// - Flag 1 on protected sector access
// - Status flags follow their condition
// - Error flags stick until clear command
// - All flags volatile, read by 70h
// - 65h reads, 61h writes config
// - 70h reads flags, 50h clears
module sfc_regs
  import sfc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic [3:0]  DQ_IN,
  output logic      [3:0]  DQ_OUT,
  output logic      [3:0]  DQ_OE_N,
  input  wire sfc_status_t STATUS,
  input  wire sfc_events_t EVENTS,
  output sfc_ecfg_t        CONFIG,
  output sfc_flags_t       FLAGS,
  output logic             QUAD_MODE,
  output logic             DUAL_MODE,
  output logic             HOLD_RESET_EN,
  output logic             ACCEL_EN
);

  function automatic logic [2:0] lanes_of(input sfc_ecfg_t c);
    if (!c.quad_n) begin
      return LANES_QUAD;
    end
    if (!c.dual_n) begin
      return LANES_DUAL;
    end
    return LANES_EXT;
  endfunction

  // Link pins cross into CLK; only stage 2 onward is looked at
  logic       sck_s1, sck_s2, sck_s3;
  logic       cs_s1, cs_s2, cs_s3;
  logic [3:0] dq_s1, dq_s2;

  sfc_state_t st;
  logic [7:0] sh_in;
  logic [3:0] cnt;
  logic [7:0] wr_data;
  logic       wr_full;
  logic       clr_armed;
  logic       rd_flags;
  logic [7:0] sh_out;
  logic [3:0] out_cnt;
  sfc_ecfg_t  ecfg;
  sfc_flags_t flags;

  wire        sck_rise  = sck_s2 & ~sck_s3;
  wire        sck_fall  = ~sck_s2 & sck_s3;
  wire        cs_rise   = cs_s2 & ~cs_s3;
  wire        active    = ~cs_s2;
  wire [2:0]  width     = lanes_of(ecfg);
  wire [3:0]  cnt_nx    = cnt + {1'b0, width};
  wire [3:0]  out_nx    = out_cnt + {1'b0, width};
  wire        byte_done = active & sck_rise & (cnt_nx == BYTE_BITS);
  wire [7:0]  in_byte   = (width == LANES_QUAD) ? {sh_in[3:0], dq_s2} :
                          (width == LANES_DUAL) ? {sh_in[5:0], dq_s2[1:0]} :
                                                  {sh_in[6:0], dq_s2[0]};
  wire [7:0]  out_shift = (width == LANES_QUAD) ? {sh_out[3:0], 4'h0} :
                          (width == LANES_DUAL) ? {sh_out[5:0], 2'h0} :
                                                  {sh_out[6:0], 1'b0};
  wire [3:0]  out_bits  = (width == LANES_QUAD) ? sh_out[7:4] :
                          (width == LANES_DUAL) ? {2'h0, sh_out[7:6]} :
                                                  {2'h0, sh_out[7], 1'b0};
  wire [3:0]  oe_mask   = (width == LANES_QUAD) ? OE_N_QUAD :
                          (width == LANES_DUAL) ? OE_N_DUAL : OE_N_EXT;
  // Reads repeat the live value, so polling sees fresh flags
  wire [7:0]  rd_value  = rd_flags ? flags : ecfg;

  // Reserved drive codes keep the previous code
  wire        drive_ok  = (wr_data[2:0] != DRIVE_RSVD_LO) &&
                          (wr_data[2:0] != DRIVE_RSVD_HI);
  wire sfc_ecfg_t next_ecfg = '{quad_n:  wr_data[7],
                                dual_n:  wr_data[6],
                                rsvd:    1'b0,
                                hold_en: wr_data[4],
                                accel_n: wr_data[3],
                                drive:   drive_ok ? wr_data[2:0]
                                                  : ecfg.drive};
  wire        ecfg_load = cs_rise & (st == ST_WR) & wr_full;
  wire        clr_hit   = cs_rise & clr_armed;
  wire        prog_set  = EVENTS.prog_fail | (EVENTS.prog_raise &
                          EVENTS.supply_high & EVENTS.len_mult64);
  // Set beats a clear landing in the same cycle
  wire sfc_flags_t next_flags = '{
    ready:      ~STATUS.busy,
    erase_susp: STATUS.erase_susp,
    erase_err:  EVENTS.erase_fail | (flags.erase_err & ~clr_hit),
    prog_err:   prog_set | (flags.prog_err & ~clr_hit),
    supply_err: EVENTS.supply_invalid |
                (flags.supply_err & ~clr_hit),
    prog_susp:  STATUS.prog_susp,
    prot_err:   EVENTS.protect_viol | (flags.prot_err & ~clr_hit),
    rsvd:       1'b0};

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3}    <= 3'h7;
      dq_s1                    <= 4'h0;
      dq_s2                    <= 4'h0;
    end else if (CE) begin
      {sck_s1, sck_s2, sck_s3} <= {SCK, sck_s1, sck_s2};
      {cs_s1, cs_s2, cs_s3}    <= {CS_N, cs_s1, cs_s2};
      dq_s1                    <= DQ_IN;
      dq_s2                    <= dq_s1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ecfg  <= ECFG_RESET;
      flags <= FLAGS_RESET;
    end else if (CE) begin
      flags <= next_flags;
      if (ecfg_load) begin
        ecfg <= next_ecfg;
      end
    end
  end

  // Command decode and inbound shifting
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st        <= ST_CMD;
      sh_in     <= 8'h00;
      cnt       <= 4'h0;
      wr_data   <= 8'h00;
      wr_full   <= 1'b0;
      clr_armed <= 1'b0;
      rd_flags  <= 1'b0;
    end else if (CE) begin
      if (!active) begin
        st        <= ST_CMD;
        cnt       <= 4'h0;
        wr_full   <= 1'b0;
        clr_armed <= 1'b0;
      end else if (sck_rise) begin
        sh_in <= in_byte;
        cnt   <= byte_done ? 4'h0 : cnt_nx;
        if (byte_done) begin
          unique case (st)
            ST_CMD: begin
              rd_flags  <= (in_byte == CMD_READ_FLAGS);
              clr_armed <= (in_byte == CMD_CLEAR_FLAGS);
              st        <= (in_byte == CMD_WRITE_ECFG) ? ST_WR :
                           (in_byte == CMD_READ_ECFG ||
                            in_byte == CMD_READ_FLAGS) ? ST_RD :
                           (in_byte == CMD_CLEAR_FLAGS) ? ST_CMD :
                                                           ST_SKIP;
              if (in_byte == CMD_CLEAR_FLAGS) begin
                st <= ST_SKIP;
              end
            end
            ST_WR: begin
              if (!wr_full) begin
                wr_data <= in_byte;
                wr_full <= 1'b1;
              end
            end
            ST_RD, ST_SKIP: begin
              // Rest of frame is ignored
            end
          endcase
        end
      end
    end
  end

  // Outbound bits change on falling clock edges
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sh_out  <= 8'h00;
      out_cnt <= 4'h0;
      DQ_OUT  <= 4'h0;
      DQ_OE_N <= OE_N_IDLE;
    end else if (CE) begin
      if (!active) begin
        DQ_OE_N <= OE_N_IDLE;
      end else if (byte_done && st == ST_CMD) begin
        sh_out  <= (in_byte == CMD_READ_FLAGS) ? flags : ecfg;
        out_cnt <= 4'h0;
      end else if (sck_fall && st == ST_RD) begin
        DQ_OUT  <= out_bits;
        DQ_OE_N <= oe_mask;
        if (out_nx == BYTE_BITS) begin
          sh_out  <= rd_value;
          out_cnt <= 4'h0;
        end else begin
          sh_out  <= out_shift;
          out_cnt <= out_nx;
        end
      end
    end
  end

  assign CONFIG        = ecfg;
  assign FLAGS         = flags;
  assign QUAD_MODE     = ~ecfg.quad_n;
  assign DUAL_MODE     = ecfg.quad_n & ~ecfg.dual_n;
  assign HOLD_RESET_EN = ecfg.hold_en;
  assign ACCEL_EN      = ~ecfg.accel_n;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  property p_quad_prio;
    !ecfg.quad_n |-> (width == LANES_QUAD) && QUAD_MODE && !DUAL_MODE;
  endproperty
  a_quad_prio: assert property (p_quad_prio)
    else $error("four-line not given priority");

  property p_dual_sel;
    (ecfg.quad_n && !ecfg.dual_n) |-> (width == LANES_DUAL) && DUAL_MODE;
  endproperty
  a_dual_sel: assert property (p_dual_sel)
    else $error("two-line selection wrong");

  property p_change_on_write;
    !$stable(ecfg) |-> $past(ecfg_load && CE);
  endproperty
  a_change_on_write: assert property (p_change_on_write)
    else $error("config changed outside write completion");

  property p_ready;
    (CE && STATUS.busy) |=> !FLAGS.ready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flag set while busy");

  property p_susp;
    CE |=> (FLAGS.erase_susp == $past(STATUS.erase_susp)) &&
           (FLAGS.prog_susp == $past(STATUS.prog_susp));
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend flags do not follow status");

  property p_erase_set;
    (CE && EVENTS.erase_fail) |=> FLAGS.erase_err;
  endproperty
  a_erase_set: assert property (p_erase_set)
    else $error("erase error not set");

  property p_prog_set;
    (CE && EVENTS.prog_raise && EVENTS.supply_high && EVENTS.len_mult64)
      |=> FLAGS.prog_err;
  endproperty
  a_prog_set: assert property (p_prog_set)
    else $error("program error not set on bad raise");

  property p_sticky;
    !(CE && clr_hit) |=> !$fell(FLAGS.erase_err) && !$fell(FLAGS.prog_err) &&
      !$fell(FLAGS.supply_err) && !$fell(FLAGS.prot_err);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag cleared without command");

  property p_clear;
    (CE && clr_hit && !EVENTS.erase_fail) |=> !FLAGS.erase_err;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear command left erase error");

  property p_rsvd;
    !FLAGS.rsvd && !CONFIG.rsvd &&
    (CONFIG.drive != DRIVE_RSVD_LO) && (CONFIG.drive != DRIVE_RSVD_HI);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit or code visible");

  c_write: cover property (ecfg_load && CE);
  c_clear: cover property (clr_hit && CE && FLAGS.prog_err);
  c_quad_read: cover property (sck_fall && st == ST_RD && QUAD_MODE);
  c_error_read: cover property (rd_flags && st == ST_RD && FLAGS.prot_err);
  c_ce_hold: cover property (!CE && EVENTS.erase_fail);

endmodule

// ===== tb/sfc_host.sv
module sfc_host
  import sfc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] dq_out,
  input  wire logic [3:0] dq_oe_n,
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] drv = 4'h0;
  logic       own = 1'b1;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
  end

  // Released lines flip, so a stale level is never mistaken for data
  always_comb
    for (int i = 0; i < 4; i++)
      dq_in[i] = !dq_oe_n[i] ? dq_out[i] : (own ? drv[i] : ~drv[i]);

  // Mode 0 frame, command in the current lane width
  // Register commands only, so no dummy phase to size
  task automatic xfer(input int lanes, input logic [7:0] cmd,
                      input int nw, input logic [7:0] wd,
                      input int nr, output logic [7:0] rd);
    logic [15:0] sh;
    int          nout;
    sh   = {cmd, wd};
    nout = (8 + 8 * nw) / lanes;
    rd   = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (int g = 0; g < nout + 8 * nr / lanes; g++) begin
      if (g < nout) begin
        drv = lanes == 4 ? sh[15:12] :
              lanes == 2 ? {2'b00, sh[15:14]} : {3'b000, sh[15]};
        sh  = sh << lanes;
      end else
        own = 1'b0;
      repeat (8) @(negedge clk);
      sck = 1'b1;
      // Read the pin, so a wrong enable corrupts the byte
      if (g >= nout)
        rd = lanes == 4 ? {rd[3:0], dq_in} :
             lanes == 2 ? {rd[5:0], dq_in[1:0]} : {rd[6:0], dq_in[1]};
      repeat (8) @(negedge clk);
      sck = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    own  = 1'b1;
    repeat (16) @(negedge clk);
  endtask
endmodule

// ===== tb/tb_sfc_regs.sv
module tb_sfc_regs
  import sfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        resetn;
  logic        ce;
  logic        sck;
  logic        cs_n;
  logic [3:0]  dq_in;
  logic [3:0]  dq_out;
  logic [3:0]  dq_oe_n;
  sfc_status_t status;
  sfc_events_t events;
  sfc_ecfg_t   cfg;
  sfc_flags_t  flags;
  logic        quad_mode;
  logic        dual_mode;
  logic        hold_en;
  logic        accel_en;
  logic [7:0]  rd;
  wire [7:0]   modes = {4'h0, quad_mode, dual_mode, hold_en, accel_en};
  int          fail_count = 0;
  int          checks_done = 0;
  logic [6:0]  ev_tab [6] = '{7'h18, 7'h40, 7'h20, 7'h1C, 7'h02, 7'h01};
  logic [7:0]  fl_tab [6] = '{8'h80, 8'hA0, 8'h90, 8'h90, 8'h88, 8'h82};

  always #2.5 clk = ~clk;

  sfc_regs uut (
    .CLK(clk), .RESETN(resetn), .CE(ce), .SCK(sck), .CS_N(cs_n),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n),
    .STATUS(status), .EVENTS(events), .CONFIG(cfg), .FLAGS(flags),
    .QUAD_MODE(quad_mode), .DUAL_MODE(dual_mode),
    .HOLD_RESET_EN(hold_en), .ACCEL_EN(accel_en)
  );

  sfc_host host (
    .clk(clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .sck(sck), .cs_n(cs_n), .dq_in(dq_in)
  );

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input int lanes, input logic [7:0] cmd,
                        input logic [7:0] exp, input string what);
    host.xfer(lanes, cmd, 0, 8'h00, 1, rd);
    chk(what, rd, exp);
  endtask

  task automatic wr_cfg(input int lanes, input logic [7:0] v);
    host.xfer(lanes, CMD_WRITE_ECFG, 1, v, 0, rd);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Generous margin over roughly 29 us of frames
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial begin
    resetn = 1'b0;
    ce     = 1'b1;
    status = '0;
    events = '0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    chk("config reset", cfg, ECFG_RESET);
    chk("flags reset", flags, FLAGS_RESET);
    chk("mode pins", modes, 8'h02);
    rd_chk(1, CMD_READ_ECFG, ECFG_RESET, "config read");
    $display("test reset done");
    wr_cfg(1, 8'hE2);
    chk("drive code", cfg, 8'hC2);
    chk("hold accel", modes, 8'h01);
    wr_cfg(1, 8'hDC);
    chk("reserved drive", cfg, 8'hDA);
    wr_cfg(1, 8'h9F);
    chk("dual select", modes, 8'h06);
    rd_chk(2, CMD_READ_ECFG, 8'h9F, "dual read");
    wr_cfg(2, 8'h1F);
    chk("both low", modes, 8'h0A);
    rd_chk(4, CMD_READ_FLAGS, FLAGS_RESET, "quad flags");
    chk("pins released", {4'h0, dq_oe_n}, {4'h0, OE_N_IDLE});
    wr_cfg(4, 8'h5F);
    chk("quad select", modes, 8'h0A);
    wr_cfg(4, 8'hDF);
    chk("back to single", cfg, 8'hDF);
    rd_chk(1, CMD_READ_ECFG, 8'hDF, "single read");
    host.xfer(1, 8'h00, 1, 8'h5F, 0, rd);
    chk("unknown command", cfg, 8'hDF);
    host.xfer(1, CMD_WRITE_ECFG, 2, 8'hDB, 0, rd);
    chk("extra bytes", cfg, 8'hDB);
    host.xfer(1, CMD_READ_ECFG, 0, 8'h00, 2, rd);
    chk("repeat read", rd, 8'hDB);
    $display("test config done");
    status = 3'b111;
    repeat (3) @(negedge clk);
    chk("status live", flags, 8'h44);
    status = 3'b000;
    repeat (3) @(negedge clk);
    chk("status ends", flags, 8'h80);
    ce     = 1'b0;
    status = 3'b111;
    events = 7'h40;
    @(negedge clk);
    events = '0;
    repeat (2) @(negedge clk);
    chk("frozen", flags, 8'h80);
    ce     = 1'b1;
    status = 3'b000;
    repeat (3) @(negedge clk);
    chk("thawed", flags, 8'h80);
    for (int i = 0; i < 6; i++) begin
      events = ev_tab[i];
      @(negedge clk);
      events = '0;
      repeat (3) @(negedge clk);
      rd_chk(1, CMD_READ_FLAGS, fl_tab[i], "error read");
      chk("error sticks", flags, fl_tab[i]);
      host.xfer(1, CMD_CLEAR_FLAGS, 0, 8'h00, 0, rd);
      chk("error cleared", flags, FLAGS_RESET);
    end
    $display("test flags done");
    wrap_up();
  end
endmodule
